// file: pdma_pkg.sv
package pdma_pkg;

    // ****************************************
    // function output register fields
    // ****************************************
    localparam int FOUT_FN1_BIT = 0;
    localparam int FOUT_FN2_BIT = 1;
    localparam int FOUT_FN3_BIT = 2;
    localparam int FOUT_GO_BIT = 4;
    localparam logic [4:0] FOUT_RESET = 5'h00;

    // ****************************************
    // function input register fields
    // ****************************************
    localparam int FIN_ADDR_BIT = 0;
    localparam int FIN_CTRL_BIT = 1;
    localparam int FIN_STC_BIT = 3;
    localparam int FIN_STB_BIT = 4;
    localparam int FIN_STA_BIT = 5;

    // ****************************************
    // configuration register fields
    // ****************************************
    localparam int CONF_BUSY_HIGH_BIT = 0;
    localparam logic CONF_RESET = 1'b0;

    // ****************************************
    // data widths and buffering
    // ****************************************
    localparam int DATA_W = 16;
    localparam int FIFO_DEPTH = 16;
    localparam int ADDR_W = 22;
    localparam logic [15:0] DATA_RESET = 16'h0000;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_PS = 4000;
    localparam int GO_PULSE_NS = 200;
    localparam int END_PULSE_NS = 100;
    localparam int INIT_PULSE_NS = 200;
    localparam logic [7:0] GO_CYCLES = 8'((GO_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [7:0] END_CYCLES = 8'((END_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [7:0] INIT_CYCLES = 8'((INIT_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

    // ****************************************
    // word cycle states
    // ****************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_FETCH = 3'b001,
        ST_PRESENT = 3'b010,
        ST_ACCEPT = 3'b011,
        ST_DONE = 3'b100
    } cyc_state_t;

endpackage

// file: pdma_fifo.sv
`timescale 1ns/1ps
module pdma_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    input wire logic flush,
    // write side
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic wr_valid,
    output logic wr_ready,
    // read side
    output logic [WIDTH-1:0] rd_data,
    output logic rd_valid,
    input wire logic rd_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wp_r;
    logic [AW:0] rp_r;
    logic [AW:0] cnt;
    logic do_wr;
    logic do_rd;

    // honest full and empty from pointer distance
    assign cnt = wp_r - rp_r;
    assign wr_ready = (cnt != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
    assign rd_valid = (cnt != '0);
    assign do_wr = wr_valid && wr_ready;
    assign do_rd = rd_valid && rd_ready;

    // storage writes
    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem[wp_r[AW-1:0]] <= wr_data;
        end
    end

    // registered read data tracks head word
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rd_data <= '0;
        end else if (do_rd && (cnt > (AW+1)'(1))) begin
            rd_data <= mem[rp_r[AW-1:0] + AW'(1)];
        end else if (do_wr && (cnt == '0 || (do_rd && cnt == (AW+1)'(1)))) begin
            rd_data <= wr_data;
        end
    end

    // pointers
    always_ff @(posedge clk) begin
        if (!rstn || flush) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            if (do_wr) begin
                wp_r <= wp_r + (AW+1)'(1);
            end
            if (do_rd) begin
                rp_r <= rp_r + (AW+1)'(1);
            end
        end
    end
endmodule

// file: pdma_port.sv
`timescale 1ns/1ps
module pdma_port (
    // clock and reset
    input wire logic CLK,
    input wire logic RSTN,
    // software register access
    input wire logic [4:0] FOUT_WDATA,
    input wire logic FOUT_WE,
    output logic [4:0] FOUT_RDATA,
    input wire logic CONF_WDATA,
    input wire logic CONF_WE,
    output logic CONF_RDATA,
    output logic [5:0] FIN_RDATA,
    output logic [15:0] IDR_RDATA,
    input wire logic [15:0] ODR_WDATA,
    input wire logic ODR_WE,
    // dma engine side
    input wire logic [15:0] DMA_RD_DATA,
    input wire logic DMA_RD_VALID,
    output logic DMA_RD_READY,
    output logic [15:0] DMA_WR_DATA,
    output logic DMA_WR_VALID,
    input wire logic DMA_WR_READY,
    output logic [21:0] DMA_ADDR,
    input wire logic [21:0] DMA_ADDR_LOAD,
    input wire logic DMA_ADDR_WE,
    output logic DMA_WORD_DONE,
    input wire logic BUS_ERROR,
    // user port inputs
    input wire logic [15:0] user_data_in,
    input wire logic cycle_request_a,
    input wire logic cycle_request_b,
    input wire logic user_abort_in,
    input wire logic direction_in,
    input wire logic byte_ctrl_in,
    input wire logic byte_addr_in,
    input wire logic addr_step_in,
    input wire logic count_step_in,
    input wire logic status_in_a,
    input wire logic status_in_b,
    input wire logic status_in_c,
    // user port outputs
    output logic [15:0] user_data_out,
    output logic READY,
    output logic GO,
    output logic BUSY,
    output logic cycle_done_pulse,
    output logic peer_init_pulse,
    output logic func_out_one,
    output logic func_out_two,
    output logic func_out_three
);

    // ****************************************
    // declarations
    // ****************************************
    pdma_pkg::cyc_state_t state_r;
    pdma_pkg::cyc_state_t state_nxt;
    logic [4:0] fout_r;
    logic conf_r;
    logic ready_r;
    logic [7:0] go_cnt_r;
    logic [7:0] end_cnt_r;
    logic [7:0] init_cnt_r;
    logic req_d_r;
    logic req_edge;
    logic busy_act;
    logic [15:0] idr_r;
    logic [15:0] odr_r;
    logic [21:0] addr_r;
    logic go_cmd;
    logic fn2_rise;
    logic done_evt;
    logic abort;
    logic in_valid;
    logic in_ready;
    logic out_pop;
    logic fifo_flush;
    logic [15:0] rx_data;
    logic rx_valid;
    logic ignored_inputs;

    // pulse timer reload or count down
    function automatic logic [7:0] tick(input logic [7:0] cnt, input logic load, input logic [7:0] len);
        if (load) begin
            return len;
        end else if (cnt != 8'h00) begin
            return cnt - 8'h01;
        end
        return 8'h00;
    endfunction

    // ****************************************
    // software controls
    // ****************************************

    // go strobe and function two rising edge
    assign go_cmd = FOUT_WE && FOUT_WDATA[pdma_pkg::FOUT_GO_BIT];
    assign fn2_rise = FOUT_WE && FOUT_WDATA[pdma_pkg::FOUT_FN2_BIT] && !fout_r[pdma_pkg::FOUT_FN2_BIT];
    // attention or bus error ends any word in flight
    assign abort = user_abort_in || BUS_ERROR;
    // these inputs take no part in transfers
    assign ignored_inputs = addr_step_in ^ count_step_in;

    // function output register, go bit self clears
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            fout_r <= pdma_pkg::FOUT_RESET;
        end else if (FOUT_WE) begin
            fout_r <= {1'b0, FOUT_WDATA[3:0]};
        end
    end

    // configuration register, busy polarity
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            conf_r <= pdma_pkg::CONF_RESET;
        end else if (CONF_WE) begin
            conf_r <= CONF_WDATA;
        end
    end

    // ready: set by reset, attention or bus error; cleared by go
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            ready_r <= 1'b1;
        end else if (abort) begin
            ready_r <= 1'b1;
        end else if (go_cmd) begin
            ready_r <= 1'b0;
        end
    end

    // go pulse timer
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            go_cnt_r <= 8'h00;
        end else begin
            go_cnt_r <= tick(go_cnt_r, go_cmd, pdma_pkg::GO_CYCLES);
        end
    end

    // peer initialize pulse timer
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            init_cnt_r <= pdma_pkg::INIT_CYCLES;
        end else begin
            init_cnt_r <= tick(init_cnt_r, fn2_rise, pdma_pkg::INIT_CYCLES);
        end
    end

    // ****************************************
    // word cycle sequencer
    // ****************************************

    // either request input starts a cycle on its rising edge if both request inputs were low the cycle before
    assign req_edge = (cycle_request_a || cycle_request_b) && !req_d_r;

    // request level one cycle back
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            req_d_r <= 1'b0;
        end else begin
            req_d_r <= cycle_request_a || cycle_request_b;
        end
    end

    // next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            pdma_pkg::ST_IDLE: begin
                if (req_edge && !ready_r) begin
                    state_nxt = direction_in ? pdma_pkg::ST_ACCEPT : pdma_pkg::ST_FETCH;
                end
            end
            pdma_pkg::ST_FETCH: begin
                if (rx_valid) begin
                    state_nxt = pdma_pkg::ST_PRESENT;
                end
            end
            pdma_pkg::ST_PRESENT: begin
                state_nxt = pdma_pkg::ST_DONE;
            end
            pdma_pkg::ST_ACCEPT: begin
                if (in_ready) begin
                    state_nxt = pdma_pkg::ST_DONE;
                end
            end
            pdma_pkg::ST_DONE: begin
                state_nxt = pdma_pkg::ST_IDLE;
            end
            default: begin
                state_nxt = pdma_pkg::ST_IDLE;
            end
        endcase
        if (abort) begin
            state_nxt = pdma_pkg::ST_IDLE;
        end
    end

    // state register
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            state_r <= pdma_pkg::ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // word completes when the sequencer leaves done
    assign done_evt = (state_r == pdma_pkg::ST_DONE) && !abort;

    // end cycle pulse timer
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            end_cnt_r <= 8'h00;
        end else begin
            end_cnt_r <= tick(end_cnt_r, done_evt, pdma_pkg::END_CYCLES);
        end
    end

    // dma address steps after each word, unless a software load lands in the same cycle and wins
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            addr_r <= '0;
        end else if (DMA_ADDR_WE) begin
            addr_r <= DMA_ADDR_LOAD;
        end else if (done_evt) begin
            addr_r <= addr_r + 22'h000001;
        end
    end

    // ****************************************
    // data paths
    // ****************************************

    // inbound word captured into input data register
    assign in_valid = (state_r == pdma_pkg::ST_ACCEPT);

    // input data register
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            idr_r <= pdma_pkg::DATA_RESET;
        end else if (in_valid && in_ready) begin
            idr_r <= user_data_in;
        end
    end

    // inbound fifo toward memory
    assign fifo_flush = user_abort_in;

    pdma_fifo #(
        .WIDTH(pdma_pkg::DATA_W),
        .DEPTH(pdma_pkg::FIFO_DEPTH)
    ) u_in_fifo (
        .clk(CLK),
        .rstn(RSTN),
        .flush(fifo_flush),
        .wr_data(user_data_in),
        .wr_valid(in_valid),
        .wr_ready(in_ready),
        .rd_data(DMA_WR_DATA),
        .rd_valid(DMA_WR_VALID),
        .rd_ready(DMA_WR_READY)
    );

    // outbound word pulled from the dma engine during fetch
    assign rx_data = DMA_RD_DATA;
    assign rx_valid = DMA_RD_VALID;
    assign out_pop = (state_r == pdma_pkg::ST_FETCH) && rx_valid;
    assign DMA_RD_READY = (state_r == pdma_pkg::ST_FETCH);

    // output data register, software or dma
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            odr_r <= pdma_pkg::DATA_RESET;
        end else if (out_pop) begin
            odr_r <= rx_data;
        end else if (ODR_WE) begin
            odr_r <= ODR_WDATA;
        end
    end

    // ****************************************
    // outputs
    // ****************************************

    // handshake active while fetching or accepting
    assign busy_act = (state_r == pdma_pkg::ST_FETCH) || (state_r == pdma_pkg::ST_ACCEPT);
    assign BUSY = conf_r ? busy_act : !busy_act;

    // status and pulse pins
    assign READY = ready_r;
    assign GO = (go_cnt_r != 8'h00);
    assign cycle_done_pulse = (end_cnt_r != 8'h00);
    assign peer_init_pulse = (init_cnt_r != 8'h00);
    assign user_data_out = odr_r;
    assign func_out_one = fout_r[pdma_pkg::FOUT_FN1_BIT];
    assign func_out_two = fout_r[pdma_pkg::FOUT_FN2_BIT];
    assign func_out_three = fout_r[pdma_pkg::FOUT_FN3_BIT];
    assign DMA_ADDR = addr_r;
    assign DMA_WORD_DONE = done_evt;

    // register read back
    assign FOUT_RDATA = fout_r;
    assign CONF_RDATA = conf_r;
    assign IDR_RDATA = idr_r;
    always_comb begin
        FIN_RDATA = 6'h00;
        FIN_RDATA[pdma_pkg::FIN_ADDR_BIT] = byte_addr_in;
        FIN_RDATA[pdma_pkg::FIN_CTRL_BIT] = byte_ctrl_in;
        FIN_RDATA[2] = 1'b0;
        FIN_RDATA[pdma_pkg::FIN_STC_BIT] = status_in_c;
        FIN_RDATA[pdma_pkg::FIN_STB_BIT] = status_in_b;
        FIN_RDATA[pdma_pkg::FIN_STA_BIT] = status_in_a;
    end

endmodule

// file: pdma_port_properties.sv
`timescale 1ns/1ps
module pdma_port_checker (
    // clock and reset
    input wire logic CLK,
    input wire logic RSTN,
    // software side
    input wire logic [4:0] FOUT_WDATA,
    input wire logic FOUT_WE,
    input wire logic CONF_RDATA,
    input wire logic [15:0] ODR_WDATA,
    input wire logic ODR_WE,
    input wire logic DMA_RD_READY,
    // user side
    input wire logic user_abort_in,
    input wire logic cycle_request_a,
    input wire logic cycle_request_b,
    input wire logic [15:0] user_data_out,
    input wire logic READY,
    input wire logic GO,
    input wire logic BUSY,
    input wire logic cycle_done_pulse,
    input wire logic DMA_WORD_DONE,
    input wire logic func_out_one,
    input wire logic func_out_two,
    input wire logic func_out_three
);
    logic [7:0] go_len_r;
    logic [7:0] done_len_r;
    logic [4:0] fout_r;
    logic [15:0] odr_r;
    wire logic go_req = FOUT_WE & FOUT_WDATA[pdma_pkg::FOUT_GO_BIT];
    wire logic busy_act = (BUSY == CONF_RDATA);
    wire logic req_any = cycle_request_a | cycle_request_b;

    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);

    // ****
    // pulse lengths
    // ****
    always_ff @(posedge CLK) begin
        go_len_r <= GO ? go_len_r + 8'h01 : 8'h00;
        done_len_r <= DMA_WORD_DONE ? 8'h00 : (cycle_done_pulse ? done_len_r + 8'h01 : 8'h00);
    end

    // write data buses one cycle back
    always_ff @(posedge CLK) begin
        fout_r <= FOUT_WDATA;
        odr_r <= ODR_WDATA;
    end

    // ****
    // properties
    // ****
    a_abort_ready: assert property (user_abort_in |-> ##[1:3] READY)
        else $error("ready not set after abort");
    a_ready_hold: assert property ($fell(READY) |-> $past(go_req))
        else $error("ready cleared without go");
    a_go_width: assert property ($fell(GO) |-> go_len_r == pdma_pkg::GO_CYCLES)
        else $error("go pulse length wrong");
    a_done_width: assert property ($fell(cycle_done_pulse) |-> done_len_r == pdma_pkg::END_CYCLES)
        else $error("end cycle pulse length wrong");
    a_func_outs: assert property (FOUT_WE |=> {func_out_three, func_out_two, func_out_one} == fout_r[2:0])
        else $error("function outputs differ from write");
    a_busy_level: assert property (READY [*3] |-> BUSY == !CONF_RDATA)
        else $error("idle handshake level wrong");
    a_request_busy: assert property ((!busy_act) [*3] ##0 (!READY && !user_abort_in && $rose(req_any))
        |-> ##[1:3] busy_act)
        else $error("request not answered by handshake");
    a_odr_shows: assert property (ODR_WE && !DMA_RD_READY |=> user_data_out == odr_r)
        else $error("data outputs differ from write");

    // main scenarios
    c_go: cover property ($fell(GO));
    c_done: cover property ($fell(cycle_done_pulse));
    c_abort: cover property ($rose(READY));
endmodule

bind pdma_port pdma_port_checker u_checker (.CLK(CLK), .RSTN(RSTN), .FOUT_WDATA(FOUT_WDATA), .FOUT_WE(FOUT_WE),
    .CONF_RDATA(CONF_RDATA), .ODR_WDATA(ODR_WDATA), .ODR_WE(ODR_WE), .DMA_RD_READY(DMA_RD_READY),
    .user_abort_in(user_abort_in), .cycle_request_a(cycle_request_a), .cycle_request_b(cycle_request_b),
    .user_data_out(user_data_out), .READY(READY), .GO(GO), .BUSY(BUSY), .cycle_done_pulse(cycle_done_pulse),
    .func_out_one(func_out_one), .func_out_two(func_out_two), .func_out_three(func_out_three),
    .DMA_WORD_DONE(DMA_WORD_DONE));

// file: user_equip.sv
`timescale 1ns/1ps
module user_equip (
    // clock
    input wire logic CLK,
    // from the device
    input wire logic BUSY,
    input wire logic busy_high,
    input wire logic [15:0] user_data_out,
    // toward the device
    output logic [15:0] user_data_in,
    output logic cycle_request_a,
    output logic cycle_request_b,
    output logic user_abort_in,
    output logic direction_in
);
    wire logic act = (BUSY === busy_high);

    // idle levels at time zero
    initial begin
        user_data_in = 16'h0000;
        cycle_request_a = 1'b0;
        cycle_request_b = 1'b0;
        user_abort_in = 1'b0;
        direction_in = 1'b0;
    end

    // one word cycle: request, follow the handshake, release
    task automatic xfer(input logic dir, input logic [15:0] d, output logic seen, output logic [15:0] q);
        int n;
        @(posedge CLK);
        direction_in <= dir;
        user_data_in <= d;
        cycle_request_a <= dir;
        cycle_request_b <= !dir;
        n = 0;
        @(posedge CLK);
        while (!act && n < 8) begin
            @(posedge CLK);
            n++;
        end
        seen = act;
        n = 0;
        while (act && n < 400) begin
            @(posedge CLK);
            n++;
        end
        q = user_data_out;
        cycle_request_a <= 1'b0;
        cycle_request_b <= 1'b0;
        user_data_in <= ~d; // released lines show the inverse
        repeat (3) @(posedge CLK);
    endtask

    // attention toward the device
    task automatic abort_pulse();
        @(posedge CLK);
        user_abort_in <= 1'b1;
        repeat (2) @(posedge CLK);
        user_abort_in <= 1'b0;
    endtask
endmodule

// file: testbench.sv
`timescale 1ns/1ps
module testbench;
    logic CLK, RSTN, FOUT_WE, CONF_WDATA, CONF_WE, ODR_WE, DMA_RD_VALID, DMA_WR_READY, DMA_ADDR_WE, BUS_ERROR;
    logic byte_ctrl_in, byte_addr_in, addr_step_in, count_step_in, status_in_a, status_in_b, status_in_c;
    logic [4:0] FOUT_WDATA, FOUT_RDATA;
    logic [15:0] ODR_WDATA, DMA_RD_DATA, IDR_RDATA, DMA_WR_DATA, user_data_in, user_data_out, q;
    logic [21:0] DMA_ADDR_LOAD, DMA_ADDR;
    logic [5:0] FIN_RDATA;
    logic CONF_RDATA, DMA_RD_READY, DMA_WR_VALID, DMA_WORD_DONE, READY, GO, BUSY, cycle_done_pulse;
    logic peer_init_pulse, func_out_one, func_out_two, func_out_three, seen;
    logic cycle_request_a, cycle_request_b, user_abort_in, direction_in;
    logic [15:0] got_q[$];
    int n_errors = 0;
    int checks = 0;
    int cycles = 0;

    pdma_port DUT (.CLK(CLK), .RSTN(RSTN), .FOUT_WDATA(FOUT_WDATA), .FOUT_WE(FOUT_WE), .FOUT_RDATA(FOUT_RDATA),
        .CONF_WDATA(CONF_WDATA), .CONF_WE(CONF_WE), .CONF_RDATA(CONF_RDATA), .FIN_RDATA(FIN_RDATA),
        .IDR_RDATA(IDR_RDATA), .ODR_WDATA(ODR_WDATA), .ODR_WE(ODR_WE), .DMA_RD_DATA(DMA_RD_DATA),
        .DMA_RD_VALID(DMA_RD_VALID), .DMA_RD_READY(DMA_RD_READY), .DMA_WR_DATA(DMA_WR_DATA),
        .DMA_WR_VALID(DMA_WR_VALID), .DMA_WR_READY(DMA_WR_READY), .DMA_ADDR(DMA_ADDR), .DMA_ADDR_LOAD(DMA_ADDR_LOAD),
        .DMA_ADDR_WE(DMA_ADDR_WE), .DMA_WORD_DONE(DMA_WORD_DONE), .BUS_ERROR(BUS_ERROR), .user_data_in(user_data_in),
        .cycle_request_a(cycle_request_a), .cycle_request_b(cycle_request_b), .user_abort_in(user_abort_in),
        .direction_in(direction_in), .byte_ctrl_in(byte_ctrl_in), .byte_addr_in(byte_addr_in),
        .addr_step_in(addr_step_in), .count_step_in(count_step_in), .status_in_a(status_in_a),
        .status_in_b(status_in_b), .status_in_c(status_in_c), .user_data_out(user_data_out), .READY(READY),
        .GO(GO), .BUSY(BUSY), .cycle_done_pulse(cycle_done_pulse), .peer_init_pulse(peer_init_pulse),
        .func_out_one(func_out_one), .func_out_two(func_out_two), .func_out_three(func_out_three));

    user_equip ue (.CLK(CLK), .BUSY(BUSY), .busy_high(CONF_RDATA), .user_data_out(user_data_out),
        .user_data_in(user_data_in), .cycle_request_a(cycle_request_a), .cycle_request_b(cycle_request_b),
        .user_abort_in(user_abort_in), .direction_in(direction_in));

    // ****
    // clock, memory sink, timeout
    // ****
    initial CLK = 1'b0;
    always #2 CLK = ~CLK;

    // words written toward memory
    always @(posedge CLK) begin
        if (DMA_WR_VALID === 1'b1 && DMA_WR_READY)
            got_q.push_back(DMA_WR_DATA);
    end

    // hang guard
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            summarize();
        end
    end

    // ****
    // access tasks
    // ****
    task automatic chk(input string nm, input logic [21:0] exp, input logic [21:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // 0 function out, 1 config, 2 output data, 3 dma address
    task automatic wr(input int sel, input logic [15:0] v);
        @(posedge CLK);
        FOUT_WDATA <= v[4:0];
        CONF_WDATA <= v[0];
        ODR_WDATA <= v;
        DMA_ADDR_LOAD <= {6'h00, v};
        FOUT_WE <= (sel == 0);
        CONF_WE <= (sel == 1);
        ODR_WE <= (sel == 2);
        DMA_ADDR_WE <= (sel == 3);
        @(posedge CLK);
        {FOUT_WE, CONF_WE, ODR_WE, DMA_ADDR_WE} <= 4'h0;
        @(negedge CLK); // let the write settle before checks
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ****
    // test sequence
    // ****
    initial begin
        {RSTN, FOUT_WE, CONF_WDATA, CONF_WE, ODR_WE, DMA_ADDR_WE, BUS_ERROR} = 7'h00;
        {byte_ctrl_in, byte_addr_in, addr_step_in, count_step_in, status_in_a, status_in_b, status_in_c} = 7'h00;
        {FOUT_WDATA, ODR_WDATA, DMA_RD_DATA, DMA_ADDR_LOAD} = 59'h0;
        DMA_RD_VALID = 1'b1;
        DMA_WR_READY = 1'b1;
        repeat (20) @(posedge CLK);
        RSTN <= 1'b1;
        @(posedge CLK);
        chk("ready", 1, READY);
        chk("busy", 1, BUSY);
        chk("go", 0, GO);
        chk("data out", 0, user_data_out);
        chk("init after reset", 1, peer_init_pulse);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            wr(0, 16'(i));
            chk("func outs", 22'(i), {func_out_three, func_out_two, func_out_one});
            chk("fout read", 22'(i), FOUT_RDATA);
            @(posedge CLK);
            status_in_a <= func_out_three;
            @(posedge CLK);
            chk("peer status", 22'(i[2]), FIN_RDATA[pdma_pkg::FIN_STA_BIT]);
        end
        wr(0, 16'h0000);
        $display("test function outputs done");
        for (int i = 0; i < 128; i++) begin
            @(posedge CLK);
            {status_in_a, status_in_b, status_in_c, byte_ctrl_in, byte_addr_in, addr_step_in, count_step_in} <= i[6:0];
            repeat (3) @(posedge CLK);
            chk("fin", 22'(i[6:2]), {FIN_RDATA[5:3], FIN_RDATA[1:0]});
        end
        $display("test function inputs done");
        chk("init idle", 0, peer_init_pulse);
        wr(0, 16'h0002);
        chk("init pulse", 1, peer_init_pulse);
        wr(0, 16'h0000);
        $display("test peer init done");
        ue.xfer(1'b1, 16'h1234, seen, q);
        chk("busy while ready", 0, seen);
        wr(2, 16'h5a3c);
        chk("odr", 16'h5a3c, user_data_out);
        wr(3, 16'h0100);
        wr(0, 16'h0010);
        chk("ready after go", 0, READY);
        chk("go pulse", 1, GO);
        $display("test go done");
        @(posedge CLK);
        DMA_RD_DATA <= 16'hc3a5;
        ue.xfer(1'b0, 16'h0000, seen, q);
        chk("busy out", 1, seen);
        chk("word out", 16'hc3a5, q);
        $display("test outbound done");
        @(posedge CLK);
        DMA_WR_READY <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            ue.xfer(1'b1, 16'h0a00 + 16'(i), seen, q);
            chk("busy in", 1, seen);
        end
        chk("idr", 16'h0a0f, IDR_RDATA);
        fork
            ue.xfer(1'b1, 16'h0a10, seen, q);
        join_none
        repeat (20) @(posedge CLK);
        chk("stalled busy", 0, BUSY);
        DMA_WR_READY <= 1'b1;
        repeat (60) @(posedge CLK);
        for (int i = 0; i < 17; i++)
            chk("fifo word", 16'h0a00 + 16'(i), got_q[i]);
        chk("addr", 22'h000112, DMA_ADDR);
        $display("test inbound buffer done");
        wr(1, 16'h0001);
        chk("conf", 1, CONF_RDATA);
        chk("busy high idle", 0, BUSY);
        ue.xfer(1'b1, 16'hbeef, seen, q);
        chk("busy high in", 1, seen);
        chk("idr", 16'hbeef, IDR_RDATA);
        $display("test polarity done");
        ue.abort_pulse();
        repeat (3) @(posedge CLK);
        chk("ready after abort", 1, READY);
        ue.xfer(1'b1, 16'h7777, seen, q);
        chk("busy after abort", 0, seen);
        $display("test abort done");
        summarize();
    end
endmodule
